// ===== design/mrf_pkg.sv
// Package with the register map, field positions and frame constants of the receive filter.
package mrf_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the register bus.
  localparam logic [7:0] ADDR_FILT_CFG = 8'h04;
  localparam logic [7:0] ADDR_HASH_HI  = 8'h08;
  localparam logic [7:0] ADDR_HASH_LO  = 8'h0c;
  localparam logic [7:0] ADDR_FLOW_CFG = 8'h18;
  localparam logic [7:0] ADDR_DA_LO    = 8'h40;
  localparam logic [7:0] ADDR_DA_HI    = 8'h44;
  localparam logic [7:0] ADDR_SA_LO    = 8'h48;
  localparam logic [7:0] ADDR_SA_HI    = 8'h4c;
  localparam logic [7:0] ADDR_STATUS   = 8'h50;

  //////////////////////////////////////////////////////////////////////////////
  // Filter configuration fields and reset values.
  localparam int          B_PROMISC     = 0;
  localparam int          B_UC_HASH     = 1;
  localparam int          B_MC_HASH     = 2;
  localparam int          B_DA_INV      = 3;
  localparam int          B_MC_ALL      = 4;
  localparam int          B_BC_REJECT   = 5;
  localparam int          B_CF_LO       = 6;
  localparam int          B_SA_INV      = 8;
  localparam int          B_SA_EN       = 9;
  localparam int          B_HASH_OR_EX  = 10;
  localparam int          B_RX_ALL      = 31;
  localparam int          B_RX_FC_EN    = 2;
  localparam int          B_ENTRY_EN    = 31;
  localparam logic [31:0] CFG_WR_MASK   = 32'h8000_07ff;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam logic [31:0] HI_WR_MASK    = 32'h8000_ffff;

  // Control frame forwarding choices.
  localparam logic [1:0] CF_BLOCK     = 2'h0;
  localparam logic [1:0] CF_NO_PAUSE  = 2'h1;
  localparam logic [1:0] CF_ALL       = 2'h2;
  localparam logic [1:0] CF_ADDR_PASS = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Descriptor status bits.
  localparam int ST_DA_FAIL  = 0;
  localparam int ST_SA_FAIL  = 1;
  localparam int ST_SA_MATCH = 2;
  localparam int ST_CTRL     = 3;
  localparam int ST_FWD      = 4;
  localparam int ST_W        = 5;

  // Frame layout and buffering.
  localparam logic [2:0]  HDR_WORDS  = 3'h4;
  localparam logic [15:0] CTRL_ETYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OP   = 16'h0001;
  localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;
  localparam int          DATA_W     = 32;
  localparam int          FIFO_DEPTH = 32;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] CRC_POLY   = 32'hedb8_8320;

endpackage

// ===== design/mrf_fifo.sv
// Module with a flip-flop FIFO carrying frame words and their last flags.
module mrf_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap at the depth, which is a power of two.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop) rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage is written at the write pointer only.
  always_ff @(posedge aclk) begin
    if (push) mem_r[wr_ptr_r] <= in_data;
  end

endmodule

// ===== design/mrf_hash.sv
// Module that turns a destination address into a hash table bit index.
module mrf_hash
  import mrf_pkg::*;
(
  input  wire logic [47:0] da,
  output logic      [5:0]  idx
);

  // Reflected checksum over the six address bytes, first bit first.
  function automatic logic [31:0] crc48(input logic [47:0] d);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < 48; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction

  logic [31:0] crc;

  // The index is the top six checksum bits, bit order reversed.
  assign crc = crc48(da);
  assign idx = {crc[26], crc[27], crc[28], crc[29], crc[30], crc[31]};

endmodule

// ===== design/mrf_filter.sv
// Module with the receive address filter, its register slave and frame buffer.
//
// Notes on behaviour
// - receive-all clear forwards only passing frames.
// - receive-all set forwards everything, status still recorded.
// - hash-or-exact select chooses hash only or either.
// - source filter compares source, flags match in status.
// - source invert turns a match into failure.
// - control field selects control frame forwarding.
// - pause action depends only on flow enable.
// - broadcast reject fails every broadcast frame unless promiscuous.
// - multicast pass-all passes every non-broadcast multicast unless destination invert is set.
// - destination invert flips unicast and multicast destination result, not broadcast.
// - multicast exact or hash by select.
// - unicast exact or hash by select.
// - promiscuous passes all non-control frames, address status bits zero.
// - hash table is two 32-bit words.
//
// Register access over AXI4-Lite is this design's own decision.
module mrf_filter
  import mrf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [DATA_W-1:0] in_data,
  input  wire logic              in_last,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [DATA_W-1:0]      out_data,
  output logic                   out_last,
  output logic                   desc_valid,
  output logic [ST_W-1:0]        desc_status,
  output logic                   pause_req
);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus slave.
  logic [31:0] cfg_r, hash_hi_r, hash_lo_r, flow_r;
  logic [31:0] da_lo_r, da_hi_r, sa_lo_r, sa_hi_r, stat_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r, wdata_r;
  logic [7:0]  waddr_r;
  logic [3:0]  wstrb_r;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [31:0] m);
    return (o & ~m) | (n & m);
  endfunction

  // Write decode works on the held address once both halves are in.
  wire        wr_go    = !awready_r && !wready_r && !bvalid_r;
  wire [31:0] wmask    = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire        ws_cfg   = (waddr_r == ADDR_FILT_CFG);
  wire        ws_hh    = (waddr_r == ADDR_HASH_HI);
  wire        ws_hl    = (waddr_r == ADDR_HASH_LO);
  wire        ws_flow  = (waddr_r == ADDR_FLOW_CFG);
  wire        ws_dal   = (waddr_r == ADDR_DA_LO);
  wire        ws_dah   = (waddr_r == ADDR_DA_HI);
  wire        ws_sal   = (waddr_r == ADDR_SA_LO);
  wire        ws_sah   = (waddr_r == ADDR_SA_HI);
  wire        wr_ok    = ws_cfg | ws_hh | ws_hl | ws_flow | ws_dal | ws_dah | ws_sal | ws_sah;

  // Read decode selects on the live address while it is taken.
  wire        rd_ok    = (araddr == ADDR_FILT_CFG) || (araddr == ADDR_HASH_HI) ||
                         (araddr == ADDR_HASH_LO) || (araddr == ADDR_FLOW_CFG) ||
                         (araddr == ADDR_DA_LO) || (araddr == ADDR_DA_HI) ||
                         (araddr == ADDR_SA_LO) || (araddr == ADDR_SA_HI) || (araddr == ADDR_STATUS);
  wire [31:0] rd_mux   = (araddr == ADDR_FILT_CFG) ? cfg_r :
                         (araddr == ADDR_HASH_HI)  ? hash_hi_r :
                         (araddr == ADDR_HASH_LO)  ? hash_lo_r :
                         (araddr == ADDR_FLOW_CFG) ? flow_r :
                         (araddr == ADDR_DA_LO)    ? da_lo_r :
                         (araddr == ADDR_DA_HI)    ? da_hi_r :
                         (araddr == ADDR_SA_LO)    ? sa_lo_r :
                         (araddr == ADDR_SA_HI)    ? sa_hi_r :
                         (araddr == ADDR_STATUS)   ? stat_r : REG_RESET;

  // Address and data are caught in either order and held until the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (awvalid && awready_r) begin
        waddr_r   <= awaddr;
        awready_r <= 1'b0;
      end else if (bvalid_r && bready) begin
        awready_r <= 1'b1;
      end
      if (wvalid && wready_r) begin
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
        wready_r <= 1'b0;
      end else if (bvalid_r && bready) begin
        wready_r <= 1'b1;
      end
    end
  end

  // Write response: unmapped or read-only offsets answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Configuration storage with byte enables; unused bits of the filter configuration and address high words stay zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r     <= REG_RESET;
      hash_hi_r <= REG_RESET;
      hash_lo_r <= REG_RESET;
      flow_r    <= REG_RESET;
      da_lo_r   <= REG_RESET;
      da_hi_r   <= REG_RESET;
      sa_lo_r   <= REG_RESET;
      sa_hi_r   <= REG_RESET;
    end else if (wr_go) begin
      if (ws_cfg) cfg_r <= merge(cfg_r, wdata_r, wmask) & CFG_WR_MASK;
      if (ws_hh) hash_hi_r <= merge(hash_hi_r, wdata_r, wmask);
      if (ws_hl) hash_lo_r <= merge(hash_lo_r, wdata_r, wmask);
      if (ws_flow) flow_r <= merge(flow_r, wdata_r, wmask);
      if (ws_dal) da_lo_r <= merge(da_lo_r, wdata_r, wmask);
      if (ws_dah) da_hi_r <= merge(da_hi_r, wdata_r, wmask) & HI_WR_MASK;
      if (ws_sal) sa_lo_r <= merge(sa_lo_r, wdata_r, wmask);
      if (ws_sah) sa_hi_r <= merge(sa_hi_r, wdata_r, wmask) & HI_WR_MASK;
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Frame intake, header capture and buffering.
  logic [2:0]        wcnt_r;
  logic [31:0]       hdr_r [HDR_WORDS];
  logic              hdr_done_r, dec_valid_r, dec_fwd_r;
  logic              out_valid_r, out_last_r, desc_valid_r, pause_req_r;
  logic [DATA_W-1:0] out_data_r;
  logic [ST_W-1:0]   desc_status_r;
  logic              f_in_ready, f_out_valid;
  logic [DATA_W:0]   f_out_data;

  // A new frame waits at its first word until the previous frame's verdict is used.
  wire stall   = (wcnt_r == '0) && (hdr_done_r || dec_valid_r);
  wire in_fire = in_valid && in_ready;
  wire pop     = dec_valid_r && f_out_valid && (!out_valid_r || out_ready || !dec_fwd_r);
  assign in_ready = f_in_ready && !stall;

  mrf_fifo #(
    .WIDTH (DATA_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (in_valid && !stall),
    .in_ready  (f_in_ready),
    .in_data   ({in_last, in_data}),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  // Word counter stops at the header length and restarts after the last word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt_r     <= '0;
      hdr_done_r <= 1'b0;
    end else begin
      hdr_done_r <= in_fire && (wcnt_r < HDR_WORDS) && (in_last || wcnt_r == HDR_WORDS - 3'h1);
      if (in_fire) wcnt_r <= in_last ? '0 : (wcnt_r == HDR_WORDS) ? wcnt_r : wcnt_r + 3'h1;
    end
  end

  // Each header word is caught at its position; a frame start clears stale words.
  for (genvar i = 0; i < HDR_WORDS; i++) begin : g_hdr
    always_ff @(posedge aclk) begin
      if (!aresetn) hdr_r[i] <= '0;
      else if (in_fire && wcnt_r == 3'(i)) hdr_r[i] <= in_data;
      else if (in_fire && wcnt_r == '0) hdr_r[i] <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address filter.
  logic [5:0] hash_idx;
  wire [47:0] da       = {hdr_r[1][15:0], hdr_r[0]};
  wire [47:0] sa       = {hdr_r[2], hdr_r[1][31:16]};
  wire [15:0] etype    = {hdr_r[3][7:0], hdr_r[3][15:8]};
  wire [15:0] opcode   = {hdr_r[3][23:16], hdr_r[3][31:24]};
  wire        is_bc    = (da == BCAST_ADDR);
  wire        is_mc    = da[0] && !is_bc;
  wire        is_ctrl  = (etype == CTRL_ETYPE);
  wire        is_pause = is_ctrl && (opcode == PAUSE_OP);
  wire        promisc  = cfg_r[B_PROMISC];
  wire [1:0]  cf_mode  = cfg_r[B_CF_LO +: 2];

  mrf_hash u_hash (
    .da  (da),
    .idx (hash_idx)
  );

  // Exact and hash comparisons of the destination.
  wire da_exact = da_hi_r[B_ENTRY_EN] && (da == {da_hi_r[15:0], da_lo_r});
  wire hash_hit = hash_idx[5] ? hash_hi_r[hash_idx[4:0]] : hash_lo_r[hash_idx[4:0]];
  wire hash_sel = cfg_r[B_HASH_OR_EX] ? (da_exact || hash_hit) : hash_hit;
  wire uc_match = cfg_r[B_UC_HASH] ? hash_sel : da_exact;
  wire mc_match = cfg_r[B_MC_ALL] ? 1'b1 :
                  cfg_r[B_MC_HASH] ? hash_sel : da_exact;
  wire grp_ok   = (is_mc ? mc_match : uc_match) ^ cfg_r[B_DA_INV];
  wire da_ok    = is_bc ? !cfg_r[B_BC_REJECT] : grp_ok;

  // Source comparison and its optional inversion.
  wire sa_hit   = cfg_r[B_SA_EN] && sa_hi_r[B_ENTRY_EN] && (sa == {sa_hi_r[15:0], sa_lo_r});
  wire sa_fail  = cfg_r[B_SA_EN] && (cfg_r[B_SA_INV] ? sa_hit : !sa_hit);

  // Promiscuous mode passes every address check and hides the address filter results.
  wire addr_ok  = promisc || (da_ok && !sa_fail);
  wire cf_ok    = (cf_mode == CF_ALL) || (cf_mode == CF_NO_PAUSE && !is_pause) ||
                  (cf_mode == CF_ADDR_PASS && addr_ok);
  wire fwd      = cfg_r[B_RX_ALL] || (is_ctrl ? cf_ok : addr_ok);

  wire [ST_W-1:0] status_nxt;
  assign status_nxt[ST_DA_FAIL]  = !promisc && !da_ok;
  assign status_nxt[ST_SA_FAIL]  = !promisc && sa_fail;
  assign status_nxt[ST_SA_MATCH] = !promisc && sa_hit;
  assign status_nxt[ST_CTRL]     = is_ctrl;
  assign status_nxt[ST_FWD]      = fwd;

  // Verdict is taken the cycle after the header is complete and held until the frame drains.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_valid_r   <= 1'b0;
      dec_fwd_r     <= 1'b0;
      desc_valid_r  <= 1'b0;
      desc_status_r <= '0;
      pause_req_r   <= 1'b0;
      stat_r        <= REG_RESET;
    end else if (hdr_done_r) begin
      dec_valid_r   <= 1'b1;
      dec_fwd_r     <= fwd;
      desc_valid_r  <= 1'b1;
      desc_status_r <= status_nxt;
      pause_req_r   <= is_pause && flow_r[B_RX_FC_EN];
      stat_r        <= {{(32 - ST_W){1'b0}}, status_nxt};
    end else begin
      desc_valid_r <= 1'b0;
      pause_req_r  <= 1'b0;
      if (pop && f_out_data[DATA_W]) dec_valid_r <= 1'b0;
    end
  end

  // Output stage: forwarded words are registered, dropped words are popped and discarded.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
      out_last_r  <= 1'b0;
    end else if (pop && dec_fwd_r) begin
      out_valid_r <= 1'b1;
      out_data_r  <= f_out_data[DATA_W-1:0];
      out_last_r  <= f_out_data[DATA_W];
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

  assign out_valid   = out_valid_r;
  assign out_data    = out_data_r;
  assign out_last    = out_last_r;
  assign desc_valid  = desc_valid_r;
  assign desc_status = desc_status_r;
  assign pause_req   = pause_req_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the filter verdict and the bus handshakes.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_verdict;
    hdr_done_r ##1 desc_valid_r;
  endsequence

  a_drop_unpassed: assert property (hdr_done_r && !cfg_r[B_RX_ALL] && !is_ctrl && !addr_ok |=> !dec_fwd_r)
    else $error("frame failing filter was forwarded");
  a_rx_all_fwd: assert property (hdr_done_r && cfg_r[B_RX_ALL] |=> dec_fwd_r && desc_valid_r)
    else $error("receive-all frame not forwarded");
  a_hash_only: assert property (hdr_done_r && cfg_r[B_UC_HASH] && !is_mc && !cfg_r[B_HASH_OR_EX]
                                && !is_bc |-> uc_match == hash_hit)
    else $error("hash-only mode used exact match");
  a_sa_status: assert property (s_verdict |-> desc_status_r[ST_SA_MATCH] == $past(sa_hit && !promisc))
    else $error("source match status wrong");
  a_sa_invert: assert property (hdr_done_r && cfg_r[B_SA_EN] && cfg_r[B_SA_INV] && sa_hit |-> sa_fail)
    else $error("inverted source match not failing");
  a_ctrl_block: assert property (hdr_done_r && is_ctrl && cf_mode == CF_BLOCK && !cfg_r[B_RX_ALL]
                                 |=> !dec_fwd_r)
    else $error("blocked control frame forwarded");
  a_pause_act: assert property (hdr_done_r && is_pause && flow_r[B_RX_FC_EN] |=> pause_req_r ##1 !pause_req_r)
    else $error("pause action missing");
  a_bc_reject: assert property (hdr_done_r && is_bc && cfg_r[B_BC_REJECT] && !promisc && !is_ctrl
                                && !cfg_r[B_RX_ALL] |=> !dec_fwd_r)
    else $error("broadcast frame not rejected");
  a_promisc_zero: assert property (s_verdict ##0 $past(promisc) |-> desc_status_r[ST_SA_FAIL:ST_DA_FAIL] == 2'h0)
    else $error("promiscuous status not zero");
  a_wr_resp: assert property (wr_go |=> bvalid_r && !awready_r && !wready_r)
    else $error("write response late");
  a_rd_hold: assert property (rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data dropped before taken");

endmodule

// ===== testbench/mrf_dma_model.sv
// Receive DMA model that drains the filter output with back-pressure.
module mrf_dma_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic hold,
  input  wire logic out_valid,
  output logic      out_ready,
  output int        n_words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_r = 1'b0;
  // Ready on alternate cycles and never while held, so words queue in the buffer.
  assign out_ready = ph_r & ~hold;
  // Counts the words taken.
  always @(posedge aclk) begin
    ph_r <= aresetn & ~ph_r;
    n_words <= n_words + int'(out_valid && out_ready);
  end
endmodule

// ===== testbench/mrf_filter_tb.sv
// Self-checking bench of the receive address filter with register master and frame source.
module mrf_filter_tb
  import mrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] cfg; logic [1:0] da; logic sa; logic [1:0] w3; logic h; logic [4:0] ex, mk;} mrf_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, in_valid = 1'b0, in_last = 1'b0, hold = 1'b0, fc = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_ready, out_last, desc_valid, pause_req;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, in_data = 32'h0, rdata, out_data, rd, od;
  logic ol;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] st, desc_status;
  int miscompares = 0, n_compared = 0, n_words, n_desc = 0, n_pause = 0, w;
  logic [47:0] da_t [4] = '{48'h5544_3322_1102, 48'heedd_ccbb_aa02, BCAST_ADDR, 48'h0100_005e_0001};
  logic [47:0] sa_t [2] = '{48'h0605_0403_0282, 48'h0a09_0807_0602};
  logic [31:0] w3_t [3] = '{32'h0000_0008, 32'h0100_0888, 32'h0200_0888};
  // Rows: config, address picks, type word, hash fill, expected status and its mask.
  mrf_row_t rows [18] = '{
    '{32'h0, 2'h0, 1'h0, 2'h0, 1'h0, 5'h10, 5'h11},
    '{32'h0, 2'h1, 1'h0, 2'h0, 1'h0, 5'h01, 5'h11},
    '{32'h8000_0000, 2'h1, 1'h0, 2'h0, 1'h0, 5'h11, 5'h11},
    '{32'h8, 2'h0, 1'h0, 2'h0, 1'h0, 5'h01, 5'h11},
    '{32'h20, 2'h2, 1'h0, 2'h0, 1'h0, 5'h00, 5'h10},
    '{32'h0, 2'h3, 1'h0, 2'h0, 1'h0, 5'h00, 5'h10},
    '{32'h4, 2'h3, 1'h0, 2'h0, 1'h1, 5'h10, 5'h10},
    '{32'h10, 2'h3, 1'h0, 2'h0, 1'h0, 5'h10, 5'h10},
    '{32'h201, 2'h1, 1'h1, 2'h0, 1'h0, 5'h10, 5'h17},
    '{32'h8000_0200, 2'h0, 1'h0, 2'h0, 1'h0, 5'h14, 5'h17},
    '{32'h8000_0300, 2'h0, 1'h0, 2'h0, 1'h0, 5'h12, 5'h12},
    '{32'h2, 2'h0, 1'h0, 2'h0, 1'h0, 5'h00, 5'h10},
    '{32'h402, 2'h0, 1'h0, 2'h0, 1'h0, 5'h10, 5'h10},
    '{32'h0, 2'h0, 1'h0, 2'h2, 1'h0, 5'h08, 5'h18},
    '{32'h40, 2'h0, 1'h0, 2'h1, 1'h0, 5'h08, 5'h18},
    '{32'h40, 2'h0, 1'h0, 2'h2, 1'h0, 5'h18, 5'h18},
    '{32'h80, 2'h1, 1'h0, 2'h2, 1'h0, 5'h18, 5'h18},
    '{32'hc0, 2'h1, 1'h0, 2'h2, 1'h0, 5'h08, 5'h18}
  };
  // Clock with an 8 ns period.
  always #4 aclk = ~aclk;
  // Keeps the last verdict and counts verdicts and pause requests.
  always @(posedge aclk) begin
    if (desc_valid === 1'b1) st <= desc_status;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      od <= out_data;
      ol <= out_last;
    end
    n_desc <= n_desc + int'(desc_valid === 1'b1);
    n_pause <= n_pause + int'(pause_req === 1'b1);
  end
  mrf_filter i_mrf_filter (.*);
  mrf_dma_model i_mrf_dma_model (.*);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int t);
    chk(32'(t < 200), 32'h1);
    if (t >= 200) print_verdict();
  endtask
  // One register access; the master waits up to 200 cycles for the answer.
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid && bready || rvalid && rready) break;
    end
    tmo(t);
    rs = wr ? bresp : rresp;
    rd = rdata;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  // Sends one frame; words past the header carry their index.
  task automatic fr(input logic [47:0] da, input logic [47:0] sa, input logic [31:0] w3, input int len);
    int t;
    @(posedge aclk);
    for (int k = 0; k < len; k++) begin
      in_data <= k == 0 ? da[31:0] : k == 1 ? {sa[15:0], da[47:32]} : k == 2 ? sa[47:16] : k == 3 ? w3 : 32'(k);
      in_valid <= 1'b1;
      in_last <= k == len - 1;
      for (t = 0; t < 200; t++) begin
        @(posedge aclk);
        if (in_ready === 1'b1) break;
      end
      tmo(t);
    end
    in_valid <= 1'b0;
  endtask
  // Programs one row, sends a five-word frame, then checks verdict, delivery and pause action.
  task automatic run(input mrf_row_t r);
    int w0, d0, p0, t;
    ax(1'b1, ADDR_FILT_CFG, r.cfg);
    ax(1'b1, ADDR_HASH_HI, {32{r.h}});
    ax(1'b1, ADDR_HASH_LO, {32{r.h}});
    w0 = n_words;
    d0 = n_desc;
    p0 = n_pause;
    fr(da_t[r.da], sa_t[r.sa], w3_t[r.w3], 5);
    for (t = 0; t < 60 && n_words - w0 != 5; t++) @(posedge aclk);
    chk(32'(n_desc - d0), 32'h1);
    chk(32'(st & r.mk), 32'(r.ex));
    chk(32'(n_words - w0), r.ex[4] ? 32'h5 : 32'h0);
    if (r.ex[4]) begin
      chk(od, 32'h4);
      chk(32'(ol), 32'h1);
    end
    chk(32'(n_pause - p0), 32'(r.w3 == 2'h1 && fc));
  endtask
  // Reset, register map, verdict table, flow enable off, then a buffer fill.
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    ax(1'b0, ADDR_FILT_CFG, 32'h0);
    chk(rd, REG_RESET);
    ax(1'b0, 8'h20, 32'h0);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    ax(1'b1, ADDR_FILT_CFG, 32'h8000_07ff);
    ax(1'b0, ADDR_FILT_CFG, 32'h0);
    chk(rd, 32'h8000_07ff);
    ax(1'b1, ADDR_FLOW_CFG, 32'h4);
    ax(1'b1, ADDR_DA_LO, da_t[0][31:0]);
    ax(1'b1, ADDR_DA_HI, {16'h8000, da_t[0][47:32]});
    ax(1'b1, ADDR_SA_LO, sa_t[0][31:0]);
    ax(1'b1, ADDR_SA_HI, {16'h8000, sa_t[0][47:32]});
    foreach (rows[i]) run(rows[i]);
    fc = 1'b0;
    ax(1'b1, ADDR_FLOW_CFG, 32'h0);
    run(rows[14]);
    ax(1'b1, ADDR_FILT_CFG, 32'h8000_0000);
    hold <= 1'b1;
    w = n_words;
    fork
      fr(da_t[1], sa_t[1], w3_t[0], 40);
      begin
        repeat (120) @(posedge aclk);
        chk(32'(in_ready), 32'h0);
        hold <= 1'b0;
      end
    join
    for (int t = 0; t < 200 && n_words - w != 40; t++) @(posedge aclk);
    chk(32'(n_words - w), 32'h28);
    chk(od, 32'h27);
    chk(32'(ol), 32'h1);
    print_verdict();
  end
endmodule
